// [hdio_pkg.sv]
package hdio_pkg;

  localparam int          NUM_PORTS    = 4;
  localparam int          PORT_W       = 8;
  localparam int          BUS_W        = NUM_PORTS * PORT_W;
  localparam int          FIFO_DEPTH   = 16;

  // Byte addresses of the register words.
  localparam logic [7:0]  ADDR_DIR     = 8'h00;
  localparam logic [7:0]  ADDR_OUT     = 8'h04;
  localparam logic [7:0]  ADDR_IN      = 8'h08;
  localparam logic [7:0]  ADDR_MODE    = 8'h0C;
  localparam logic [7:0]  ADDR_GROUP   = 8'h10;
  localparam logic [7:0]  ADDR_STATUS  = 8'h14;
  localparam logic [7:0]  ADDR_FIFO    = 8'h18;
  localparam logic [7:0]  ADDR_IMPL    = 8'h1C;

  // Mode register fields.
  localparam int          MODE_SEL_LSB = 0;
  localparam int          MODE_EDGE    = 2;
  localparam int          MODE_REQ_INV = 3;
  localparam int          MODE_ACK_INV = 4;

  // Status register fields.
  localparam int          ST_IN_LATCH  = 0;
  localparam int          ST_OUT_ACC   = 1;
  localparam int          ST_FIFO_EMP  = 2;
  localparam int          ST_FIFO_FULL = 3;

  // Lines that exist and ports whose direction is hard-wired.
  localparam logic [31:0] IMPL_MASK    = 32'h0FFF_FFFF;
  localparam logic [3:0]  FIXED_PORTS  = 4'h8;
  localparam logic [3:0]  FIXED_OUTPUT = 4'h0;

  localparam logic [31:0] DIR_RESET    = 32'h0000_0000;
  localparam logic [31:0] OUT_RESET    = 32'h0000_0000;
  localparam logic [31:0] MODE_RESET   = 32'h0000_0000;
  localparam logic [31:0] GROUP_RESET  = 32'h0000_0000;

  // Width of the handshake pulse sent on an output write or request in handshake mode.
  localparam int          ACK_NS       = 80;
  localparam int          CLK_NS       = 40;
  localparam int          ACK_CYCLES   = (ACK_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {
    HDIO_PLAIN,
    HDIO_HANDSHAKE,
    HDIO_CLOCKED
  } hdio_mode_type;

  typedef enum {
    HDIO_IDLE,
    HDIO_PULSE
  } hdio_state_type;

endpackage

// [hdio_fifo.sv]
`timescale 1ns/1ps
module hdio_fifo
  import hdio_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  wire              push;
  wire              pop;

  assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rd_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else if (flush) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + AW'(1);
      end
      if (pop) begin
        rd_reg <= rd_reg + AW'(1);
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

// [hdio_port.sv]
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
module hdio_port
  import hdio_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic [BUS_W-1:0] line_in,
  output logic      [BUS_W-1:0] line_out,
  output logic      [BUS_W-1:0] line_oe,
  input  wire logic             req_in,
  output logic                  ack_out,
  input  wire logic             xfer_clk
);

  ////////////////////////////////////////////////////////////////////////
  logic [31:0]    dir_reg;
  logic [31:0]    out_reg;
  logic [31:0]    mode_reg;
  logic [31:0]    group_reg;
  logic [31:0]    latch_reg;
  logic           in_flag_reg;
  logic           out_flag_reg;
  logic           req_reg;
  logic           xclk_reg;
  logic [1:0]     pulse_cnt_reg;
  hdio_state_type state_reg;
  logic [31:0]    prdata_reg;
  logic           pready_reg;
  logic           pslverr_reg;
  logic [31:0]    line_out_reg;
  logic [31:0]    line_oe_reg;
  logic           ack_reg;

  function automatic logic [31:0] port_mask(input logic [3:0] p);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (p[i]) begin
        m[i*PORT_W +: PORT_W] = 8'hFF;
      end
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  wire           access   = psel && penable;
  wire           wr_en    = access && pwrite;
  wire           rd_en    = access && !pwrite;
  wire [1:0]     mode_sel = mode_reg[MODE_SEL_LSB +: 2];
  wire           grouped  = (group_reg != '0);
  // Handshake only takes effect on a group; ungrouped stays plain.
  wire           hs_mode  = grouped && (mode_sel == 2'(HDIO_HANDSHAKE));
  wire           ck_mode  = grouped && (mode_sel == 2'(HDIO_CLOCKED));
  wire [31:0]    fix_mask = port_mask(FIXED_PORTS);
  wire [31:0]    fix_dir  = port_mask(FIXED_OUTPUT);
  // Per-line direction; fixed ports ignore writes.
  wire [31:0]    dir_eff  = ((dir_reg & ~fix_mask) | (fix_dir & fix_mask))
                            & IMPL_MASK;
  // Edges come from the raw pins, so a polarity change fakes no edge.
  wire           req_rise = mode_reg[MODE_REQ_INV] ? (!req_in && req_reg)
                                                   : (req_in && !req_reg);
  // Selected edge of the transfer clock.
  wire           ck_edge  = mode_reg[MODE_EDGE] ? (!xfer_clk && xclk_reg)
                                                : (xfer_clk && !xclk_reg);
  wire           strobe   = (hs_mode && req_rise) || (ck_mode && ck_edge);
  wire [31:0]    grp_in   = group_reg & ~dir_eff;
  wire [31:0]    grp_out  = group_reg & dir_eff;
  // The group moves as one word of any width or line set.
  wire [31:0]    in_view  = (line_in & ~grp_in) | (latch_reg & grp_in);
  // Ungrouped inputs read live, grouped inputs read the latch, outputs read back.
  wire [31:0]    rd_port  = ((in_view & ~dir_eff) | (out_reg & dir_eff))
                            & IMPL_MASK;
  wire           out_wr   = wr_en && (paddr == ADDR_OUT);
  wire           in_rd    = rd_en && (paddr == ADDR_IN);
  wire           fifo_wr  = wr_en && (paddr == ADDR_FIFO);
  wire           fifo_rd  = rd_en && (paddr == ADDR_FIFO);
  wire           f_in_rdy;
  wire           f_out_vld;
  wire [31:0]    f_data;
  wire           known    = (paddr <= ADDR_IMPL) && (paddr[1:0] == 2'b00);
  wire [31:0]    status   = {28'h0, !f_in_rdy, !f_out_vld,
                             out_flag_reg, in_flag_reg};
  logic [31:0]   rd_mux;

  always_comb begin
    case (paddr)
      ADDR_DIR:    rd_mux = dir_eff;
      ADDR_OUT:    rd_mux = out_reg & IMPL_MASK;
      ADDR_IN:     rd_mux = rd_port;
      ADDR_MODE:   rd_mux = mode_reg;
      ADDR_GROUP:  rd_mux = group_reg;
      ADDR_STATUS: rd_mux = status;
      ADDR_FIFO:   rd_mux = f_out_vld ? f_data : 32'h0000_0000;
      ADDR_IMPL:   rd_mux = IMPL_MASK;
      default:     rd_mux = 32'h0000_0000;
    endcase
  end

  // Strobed input words queue here so a burst outruns software reads.
  hdio_fifo #(
    .WIDTH (BUS_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .flush     (wr_en && (paddr == ADDR_GROUP)),
    .in_valid  (strobe && (grp_in != '0)),
    .in_ready  (f_in_rdy),
    .in_data   (line_in & grp_in),
    .out_valid (f_out_vld),
    .out_ready (fifo_rd),
    .out_data  (f_data)
  );

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dir_reg   <= DIR_RESET;
      out_reg   <= OUT_RESET;
      mode_reg  <= MODE_RESET;
      group_reg <= GROUP_RESET;
    end else if (wr_en) begin
      case (paddr)
        ADDR_DIR:   dir_reg   <= pwdata;
        ADDR_OUT:   out_reg   <= pwdata;
        ADDR_MODE:  mode_reg  <= pwdata;
        ADDR_GROUP: group_reg <= pwdata & IMPL_MASK;
        default:    dir_reg   <= dir_reg;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      latch_reg    <= '0;
      in_flag_reg  <= 1'b0;
      out_flag_reg <= 1'b0;
      req_reg      <= 1'b0;
      xclk_reg     <= 1'b0;
    end else begin
      req_reg  <= req_in;
      xclk_reg <= xfer_clk;
      if (strobe) begin
        latch_reg <= (latch_reg & ~grp_in) | (line_in & grp_in);
      end
      // Set wins over the host-access clear.
      in_flag_reg  <= (strobe && grp_in != '0) || (in_flag_reg && !in_rd);
      out_flag_reg <= (strobe && grp_out != '0) || (out_flag_reg && !out_wr);
    end
  end

  // Output launch: immediate in plain mode, on a strobe in clocked mode.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      line_out_reg <= '0;
      line_oe_reg  <= '0;
    end else begin
      line_oe_reg <= dir_eff;
      if (!ck_mode || strobe) begin
        line_out_reg <= (out_reg & dir_eff);
      end
    end
  end

  // Acknowledge pulse in handshake mode only, on an output write or on a request rise with grouped inputs.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg     <= HDIO_IDLE;
      pulse_cnt_reg <= '0;
      ack_reg       <= 1'b0;
    end else begin
      case (state_reg)
        HDIO_IDLE: begin
          if (hs_mode && (out_wr || (req_rise && grp_in != '0))) begin
            state_reg     <= HDIO_PULSE;
            pulse_cnt_reg <= 2'(ACK_CYCLES - 1);
            ack_reg       <= 1'b1;
          end
        end
        HDIO_PULSE: begin
          if (pulse_cnt_reg == '0) begin
            state_reg <= HDIO_IDLE;
            ack_reg   <= 1'b0;
          end else begin
            pulse_cnt_reg <= pulse_cnt_reg - 2'd1;
          end
        end
        default: begin
          state_reg <= HDIO_IDLE;
          ack_reg   <= 1'b0;
        end
      endcase
    end
  end

  // Zero-wait slave; read data is registered at the setup cycle.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prdata_reg  <= '0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= psel && !penable;
      pslverr_reg <= psel && !penable && !known;
      if (psel && !penable && !pwrite) begin
        prdata_reg <= rd_mux;
      end
    end
  end

  assign prdata   = prdata_reg;
  assign pready   = pready_reg;
  assign pslverr  = pslverr_reg;
  assign line_out = line_out_reg;
  assign line_oe  = line_oe_reg;
  assign ack_out  = ack_reg ^ mode_reg[MODE_ACK_INV];

endmodule

// [hdio_checker.sv]
`timescale 1ns/1ps
module hdio_checker
  import hdio_pkg::*;
(
  input wire logic             core_clk,
  input wire logic             nrst,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic [BUS_W-1:0] line_in,
  input wire logic [BUS_W-1:0] line_out,
  input wire logic [BUS_W-1:0] line_oe,
  input wire logic             req_in,
  input wire logic             ack_out,
  input wire logic             xfer_clk
);
  logic [4:0] mode_reg;
  wire        wr_acc  = psel && penable && pready && pwrite;
  wire        ack_raw = ack_out ^ mode_reg[4];
  // Mirror of the mode word, so the ack polarity and plain mode are known.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mode_reg <= 5'h00;
    end else if (wr_acc && paddr == ADDR_MODE) begin
      mode_reg <= pwdata[4:0];
    end
  end
  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  sequence ack_pulse_s;
    ack_raw ##1 ack_raw ##1 !ack_raw;
  endsequence
  ready_setup_a: assert property ((psel && !penable) |=> pready)
    else $error("late ready");
  err_unmapped_a:
    assert property ((pready && (paddr > ADDR_IMPL || paddr[1:0] != 2'h0))
      |-> pslverr) else $error("no error");
  err_data_a: assert property ((pslverr && !pwrite) |-> prdata == '0)
    else $error("error read data");
  out_masked_a: assert property ((line_out & ~line_oe) == '0)
    else $error("input line driven");
  fixed_input_a: assert property (line_oe[31:24] == 8'h00)
    else $error("fixed port driven");
  plain_out_a:
    assert property ((wr_acc && paddr == ADDR_OUT && mode_reg[1:0] == 2'h0)
      |-> ##2 line_out == ($past(pwdata, 2) & line_oe))
    else $error("bad out");
  ack_len_a: assert property ($rose(ack_raw) |-> ack_pulse_s)
    else $error("bad ack pulse");
  plain_noack_a:
    assert property ((mode_reg[1:0] == 2'h0 && $past(mode_reg[1:0], 3) == 2'h0)
      |-> !ack_raw) else $error("ack in plain mode");
endmodule
bind hdio_port hdio_checker chk_u (.core_clk(core_clk), .nrst(nrst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .line_in(line_in), .line_out(line_out), .line_oe(line_oe),
  .req_in(req_in), .ack_out(ack_out), .xfer_clk(xfer_clk));

// [hdio_ext_dev.sv]
`timescale 1ns/1ps
module hdio_ext_dev
  import hdio_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic [BUS_W-1:0] line_out,
  input  wire logic [BUS_W-1:0] line_oe,
  output logic      [BUS_W-1:0] line_in,
  output logic                  req_in,
  output logic                  xfer_clk
);
  logic [BUS_W-1:0] drv_reg = 32'h0000_0000;
  assign line_in = (line_oe & line_out) | (~line_oe & drv_reg);
  initial begin
    req_in = 1'b0;
    xfer_clk = 1'b0;
  end
  task automatic set_lines(input logic [BUS_W-1:0] d);
    @(posedge core_clk) drv_reg <= d;
  endtask
  // Data flips to its inverse before the strobe falls, so a latch on the
  // wrong edge or too late shows up as inverted data.
  task automatic strobe(input logic [BUS_W-1:0] d, input logic use_clk);
    @(posedge core_clk) drv_reg <= d;
    repeat (2) @(posedge core_clk);
    if (use_clk) begin
      xfer_clk <= 1'b1;
    end else begin
      req_in <= 1'b1;
    end
    repeat (4) @(posedge core_clk);
    drv_reg <= ~d;
    repeat (4) @(posedge core_clk);
    xfer_clk <= 1'b0;
    req_in <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top
  import hdio_pkg::*;
();
  localparam logic [31:0] full_mask = 32'hFFFF_FFFF;
  logic             core_clk, nrst, psel, penable, pwrite, e;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, r;
  logic             pready, pslverr, req_in, ack_out, xfer_clk;
  logic [BUS_W-1:0] line_in, line_out, line_oe;
  int               errors, check_count;
  hdio_port dut_u (.core_clk(core_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .line_in(line_in),
    .line_out(line_out), .line_oe(line_oe), .req_in(req_in),
    .ack_out(ack_out), .xfer_clk(xfer_clk));
  hdio_ext_dev dev_u (.core_clk(core_clk), .line_out(line_out),
    .line_oe(line_oe), .line_in(line_in), .req_in(req_in),
    .xfer_clk(xfer_clk));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      errors++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, s, x);
    end
  endtask
  // The answer is taken at the rising edge where pready is seen high.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      finish_test();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, x);
    apb(a, 1'b0, 32'h0000_0000);
    chk(r & m, x);
  endtask
  initial begin
    {nrst, psel, penable, pwrite} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    rdc(ADDR_DIR, full_mask, DIR_RESET);
    rdc(ADDR_IMPL, full_mask, IMPL_MASK);
    rdc(ADDR_STATUS, full_mask, 32'h0000_0004);
    apb(8'h22, 1'b1, full_mask);
    chk({31'h0, e}, 32'h1);
    apb(ADDR_DIR, 1'b1, full_mask);
    rdc(ADDR_DIR, full_mask, 32'h00FF_FFFF);
    apb(ADDR_DIR, 1'b1, 32'h0000_00A5);
    apb(ADDR_OUT, 1'b1, 32'h1234_5678);
    repeat (2) @(negedge core_clk);
    chk(line_out, 32'h0000_0020);
    dev_u.set_lines(32'hC3C3_C3C3);
    rdc(ADDR_IN, full_mask, 32'h03C3_C362);
    apb(ADDR_MODE, 1'b1, 32'h0000_0001);
    dev_u.strobe(32'h0000_5A00, 1'b0);
    rdc(ADDR_STATUS, full_mask, 32'h0000_0004);
    apb(ADDR_GROUP, 1'b1, 32'h0000_F800);
    apb(ADDR_MODE, 1'b1, 32'h0000_0000);
    dev_u.strobe(32'h0000_5A00, 1'b0);
    rdc(ADDR_STATUS, full_mask, 32'h0000_0004);
    apb(ADDR_MODE, 1'b1, 32'h0000_0001);
    dev_u.strobe(32'h0000_5A00, 1'b0);
    rdc(ADDR_STATUS, full_mask, 32'h0000_0001);
    rdc(ADDR_IN, 32'h0000_F800, 32'h0000_5800);
    rdc(ADDR_STATUS, full_mask, 32'h0000_0000);
    rdc(ADDR_FIFO, 32'h0000_F800, 32'h0000_5800);
    for (int i = 0; i <= FIFO_DEPTH; i++) begin
      dev_u.strobe(32'(i) << 11, 1'b0);
    end
    rdc(ADDR_STATUS, 32'h0000_000C, 32'h0000_0008);
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      rdc(ADDR_FIFO, 32'h0000_F800, 32'(i) << 11);
    end
    rdc(ADDR_STATUS, 32'h0000_000C, 32'h0000_0004);
    apb(ADDR_DIR, 1'b1, 32'h0000_00FF);
    apb(ADDR_GROUP, 1'b1, 32'h0000_00FF);
    apb(ADDR_OUT, 1'b1, 32'h0000_003C);
    repeat (2) @(negedge core_clk);
    chk({31'h0, ack_out}, 32'h1);
    chk(line_out, 32'h0000_003C);
    dev_u.strobe(32'h0000_0000, 1'b0);
    rdc(ADDR_STATUS, 32'h0000_0002, 32'h0000_0002);
    apb(ADDR_OUT, 1'b1, 32'h0000_00C3);
    rdc(ADDR_STATUS, 32'h0000_0002, 32'h0000_0000);
    apb(ADDR_DIR, 1'b1, 32'h0000_0000);
    apb(ADDR_GROUP, 1'b1, 32'h00FF_FF00);
    apb(ADDR_MODE, 1'b1, 32'h0000_0002);
    dev_u.strobe(32'h0096_9600, 1'b1);
    rdc(ADDR_FIFO, 32'h00FF_FF00, 32'h0096_9600);
    apb(ADDR_MODE, 1'b1, 32'h0000_0006);
    dev_u.strobe(32'h0096_9600, 1'b1);
    rdc(ADDR_FIFO, 32'h00FF_FF00, 32'h0069_6900);
    finish_test();
  end
endmodule
